// ===== tss_operator_model.sv
// operator keys and generator phase levels facing the sequencer
`timescale 1ns/10ps
module tss_operator_model (
  input wire logic mclk,
  input wire logic [1:0] keyCmd,
  output logic continueKey,
  output logic branchOneKey,
  output logic branchTwoKey,
  output logic onPhaseReached,
  output logic offPhaseReached
);
  int hold = 0; // cycles left on a pressed key
  logic [1:0] key = 2'h0; // 1 continue, 2 branch one, 3 branch two
  initial {continueKey, branchOneKey, branchTwoKey, onPhaseReached, offPhaseReached} = 5'h00;
  // key held several cycles so the pin synchroniser sees one clean edge
  always @(posedge mclk)
  begin
    if (keyCmd != 2'h0)
    begin
      key <= keyCmd;
      hold <= 6;
    end
    else if (hold > 0)
      hold <= hold - 1;
    continueKey <= hold != 0 && key == 2'h1;
    branchOneKey <= hold != 0 && key == 2'h2;
    branchTwoKey <= hold != 0 && key == 2'h3;
    // generator reaches phase sometimes late, sometimes at once
    onPhaseReached <= $urandom_range(0, 3) == 0;
    offPhaseReached <= $urandom_range(0, 3) == 0;
  end
endmodule

// ===== tss_pkg.sv
// shared constants, field layouts and types of the test step sequencer
package tss_pkg;
  // program size
  localparam int STEP_MAX = 999;
  localparam int STEPW = 10;
  localparam int WORDS_PER_STEP = 8;
  localparam int MEM_AW = 13;
  localparam int MEM_DEPTH = 8000;
  // register byte offsets
  localparam logic [15:0] OFF_CTRL = 16'h0000;
  localparam logic [15:0] OFF_CONFIG = 16'h0004;
  localparam logic [15:0] OFF_LAST = 16'h0008;
  localparam logic [15:0] OFF_STATUS = 16'h000C;
  localparam logic [15:0] OFF_LOOP = 16'h0010;
  localparam logic [15:0] OFF_MEMBASE = 16'h8000;
  // command bits, write one to fire
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_CONT = 2;
  localparam int CTRL_BR1 = 3;
  localparam int CTRL_BR2 = 4;
  // config fields and reset values
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_RANGE = 2;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [9:0] LAST_RST = 10'h001;
  // status fields
  localparam int ST_RUNNING = 0;
  localparam int ST_HOLDING = 1;
  localparam int ST_BRANCH = 2;
  localparam int ST_STEP_LSB = 16;
  // word slots inside one step record
  localparam logic [2:0] W_DUR = 3'h0;
  localparam logic [2:0] W_LAST = 3'h6;
  // jump word
  localparam int J_EN = 10;
  localparam int J_CNT_LSB = 11;
  localparam int TERM_LSB = 25;
  localparam int SYNC_LSB = 27;
  // branch word
  localparam int B1_EN = 10;
  localparam int B2_LSB = 11;
  localparam int B2_EN = 21;
  // frequency/wave word and phase word
  localparam int WAVE_LSB = 16;
  localparam int ON_FIX = 12;
  localparam int OFF_LSB = 16;
  localparam int OFF_FIX = 28;
  // step time unit and its cycle count
  localparam int STEP_UNIT_NS = 100000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_CYCLES = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // voltage spans, ac in 10 mV, dc in 100 mV
  localparam logic [15:0] ACV_MAX_LO = 16'h445C;
  localparam logic [15:0] ACV_MAX_HI = 16'h88B8;
  localparam logic signed [15:0] DCV_MAX_LO = 16'sh09C4;
  localparam logic signed [15:0] DCV_MAX_HI = 16'sh1388;
  // load goals
  localparam logic [1:0] GOAL_START = 2'h0;
  localparam logic [1:0] GOAL_RESUME = 2'h1;
  localparam logic [1:0] GOAL_STANDBY = 2'h2;
  typedef enum logic [1:0] {
    TSS_TERM_CONTINUE_TO_NEXT = 2'b00,
    TSS_TERM_END = 2'b01,
    TSS_TERM_HOLD = 2'b10
  } tss_term_t;
  typedef enum logic [1:0] {
    TSS_MODE_OTHER = 2'b00,
    TSS_MODE_INTERNAL_DC = 2'b01,
    TSS_MODE_INTERNAL_AC = 2'b10,
    TSS_MODE_INTERNAL_ACDC = 2'b11
  } tss_mode_t;
  typedef enum logic [2:0] {
    TSS_IDLE = 3'b000,
    TSS_LOAD = 3'b001,
    TSS_ONWAIT = 3'b010,
    TSS_RUN = 3'b011,
    TSS_OFFWAIT = 3'b100,
    TSS_DECIDE = 3'b101,
    TSS_HOLD = 3'b110
  } tss_state_t;
endpackage

// ===== tss_step_mem.sv
// step record store, one write port and one registered read port
`timescale 1ns/10ps
module tss_step_mem #(
  parameter int DW = 32,
  parameter int AW = 13,
  parameter int DEPTH = 8000
) (
  input wire logic mclk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  // plain array, no reset so it maps onto block ram
  logic [DW-1:0] mem [DEPTH];
  // write side
  always_ff @(posedge mclk)
  begin
    if (wrEn && (int'(wrAddr) < DEPTH))
    begin
      mem[wrAddr] <= wrData;
    end
  end
  // read side, one cycle latency
  always_ff @(posedge mclk)
  begin
    rdData <= mem[rdAddr];
  end
endmodule

// ===== tss_test_step_sequencer.sv
// test step sequencer with avalon register slave and step store
`timescale 1ns/10ps
module tss_test_step_sequencer
  import tss_pkg::*;
#(
  parameter int STEPS = STEP_MAX
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic branchOneKey,
  input wire logic branchTwoKey,
  input wire logic continueKey,
  input wire logic onPhaseReached,
  input wire logic offPhaseReached,
  output logic [STEPW-1:0] stepNumber,
  output logic stepActive,
  output logic holdActive,
  output logic [15:0] acVoltage,
  output logic signed [15:0] dcVoltage,
  output logic [15:0] frequency,
  output logic [7:0] waveSel,
  output logic [11:0] onPhase,
  output logic onPhaseFixed,
  output logic [11:0] offPhase,
  output logic offPhaseFixed,
  output logic [1:0] syncCode,
  output logic rangeHigh
);
  // clamp ac level to the span of the selected range
  function automatic logic [15:0] clampAc(input logic [15:0] v, input logic hi);
    logic [15:0] lim;
    lim = hi ? ACV_MAX_HI : ACV_MAX_LO;
    return (v > lim) ? lim : v;
  endfunction
  // clamp signed dc level symmetrically
  function automatic logic signed [15:0] clampDc(input logic signed [15:0] v, input logic hi);
    logic signed [15:0] lim;
    lim = hi ? DCV_MAX_HI : DCV_MAX_LO;
    return (v > lim) ? lim : ((v < -lim) ? -lim : v);
  endfunction

  // bus slave state
  logic waitReq_r, waitReq_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic [1:0] modeSel_r, modeSel_nxt;
  logic rangeHi_r, rangeHi_nxt;
  logic [STEPW-1:0] lastStep_r, lastStep_nxt;
  logic [4:0] cmd_r, cmd_nxt; // one-cycle command pulses
  logic memWrEn_r, memWrEn_nxt;
  logic [MEM_AW-1:0] memWrAddr_r, memWrAddr_nxt;
  logic [31:0] memWrData_r, memWrData_nxt;
  // key synchronisers
  logic [2:0] keyMeta_r, keySync_r, keyPrev_r;
  logic [2:0] keyEdge;
  // sequencer state
  tss_state_t state_r, state_nxt;
  logic [STEPW-1:0] loadStep_r, loadStep_nxt, curStep_r, curStep_nxt;
  logic [2:0] loadWord_r, loadWord_nxt;
  logic [1:0] loadGoal_r, loadGoal_nxt;
  logic [31:0] durW_r, durW_nxt, jumpW_r, jumpW_nxt, brW_r, brW_nxt;
  logic [31:0] voltW_r, voltW_nxt, freqW_r, freqW_nxt, phW_r, phW_nxt;
  logic [11:0] tick_r, tick_nxt;
  logic [31:0] rem_r, rem_nxt;
  logic [STEPW-1:0] loopStep_r, loopStep_nxt;
  logic [13:0] loopCnt_r, loopCnt_nxt;
  logic inBranch_r, inBranch_nxt, retHold_r, retHold_nxt;
  logic [STEPW-1:0] retStep_r, retStep_nxt;
  logic [31:0] retRem_r, retRem_nxt;
  logic outLatch; // load done, drive the new step
  logic [31:0] memRdData;
  // request terms
  logic contGo, br1Go, br2Go, modeOk;
  logic [STEPW-1:0] nextStep;
  logic atLast;

  tss_step_mem #(.DW(32), .AW(MEM_AW), .DEPTH(MEM_DEPTH)) stepMem (
    .mclk(mclk),
    .wrEn(memWrEn_r),
    .wrAddr(memWrAddr_r),
    .wrData(memWrData_r),
    .rdAddr({loadStep_r, loadWord_r}),
    .rdData(memRdData)
  );

  // keys arrive from panel pins, two flops then edge detect
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      keyMeta_r <= 3'h0;
      keySync_r <= 3'h0;
      keyPrev_r <= 3'h0;
    end
    else
    begin
      keyMeta_r <= {continueKey, branchTwoKey, branchOneKey};
      keySync_r <= keyMeta_r;
      keyPrev_r <= keySync_r;
    end
  end
  assign keyEdge = keySync_r & ~keyPrev_r;
  // local and remote requests merge here
  assign contGo = cmd_r[CTRL_CONT] | keyEdge[2];
  assign br1Go = cmd_r[CTRL_BR1] | keyEdge[0];
  assign br2Go = cmd_r[CTRL_BR2] | keyEdge[1];
  assign modeOk = (modeSel_r != TSS_MODE_OTHER);

  // bus: one wait cycle, then a single low cycle completes the access
  always_comb
  begin
    waitReq_nxt = !((avs_read || avs_write) && waitReq_r);
    rdData_nxt = rdData_r;
    modeSel_nxt = modeSel_r;
    rangeHi_nxt = rangeHi_r;
    lastStep_nxt = lastStep_r;
    cmd_nxt = 5'h00;
    memWrEn_nxt = 1'b0;
    memWrAddr_nxt = avs_address[MEM_AW+1:2];
    memWrData_nxt = avs_writedata;
    // read data prepared while waitrequest is still high
    if (avs_read && waitReq_r)
    begin
      case (avs_address)
        OFF_CONFIG: rdData_nxt = {29'h0, rangeHi_r, modeSel_r};
        OFF_LAST: rdData_nxt = {22'h0, lastStep_r};
        OFF_STATUS: rdData_nxt = {6'h0, curStep_r, 13'h0, inBranch_r,
                                  state_r == TSS_HOLD, state_r != TSS_IDLE};
        OFF_LOOP: rdData_nxt = {18'h0, loopCnt_r};
        default: rdData_nxt = 32'h0; // ctrl, store and holes read zero
      endcase
    end
    // writes act at the edge that sees waitrequest low
    if (avs_write && !waitReq_r)
    begin
      if (avs_address[15])
      begin
        memWrEn_nxt = (avs_byteenable == 4'hF); // store takes whole words
      end
      else if (avs_byteenable[0])
      begin
        case (avs_address)
          OFF_CTRL: cmd_nxt = avs_writedata[4:0];
          OFF_CONFIG:
          begin
            modeSel_nxt = avs_writedata[CFG_MODE_LSB +: 2];
            rangeHi_nxt = avs_writedata[CFG_RANGE];
          end
          OFF_LAST:
          begin
            // cap the program length at the store size
            lastStep_nxt = (int'(avs_writedata[9:0]) > STEPS - 1) ?
                           STEPW'(STEPS - 1) : avs_writedata[9:0];
          end
          default: cmd_nxt = 5'h00; // unmapped: write dropped
        endcase
      end
    end
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitReq_r <= 1'b1;
      rdData_r <= 32'h0;
      modeSel_r <= MODE_RST;
      rangeHi_r <= 1'b0;
      lastStep_r <= LAST_RST;
      cmd_r <= 5'h00;
      memWrEn_r <= 1'b0;
      memWrAddr_r <= '0;
      memWrData_r <= 32'h0;
    end
    else
    begin
      waitReq_r <= waitReq_nxt;
      rdData_r <= rdData_nxt;
      modeSel_r <= modeSel_nxt;
      rangeHi_r <= rangeHi_nxt;
      lastStep_r <= lastStep_nxt;
      cmd_r <= cmd_nxt;
      memWrEn_r <= memWrEn_nxt;
      memWrAddr_r <= memWrAddr_nxt;
      memWrData_r <= memWrData_nxt;
    end
  end
  assign avs_waitrequest = waitReq_r;
  assign avs_readdata = rdData_r;

  assign atLast = (curStep_r >= lastStep_r);
  assign nextStep = curStep_r + STEPW'(1);

  // sequencer: load a step record, wait phases, time it, decide
  always_comb
  begin
    state_nxt = state_r;
    loadStep_nxt = loadStep_r;
    loadWord_nxt = loadWord_r;
    loadGoal_nxt = loadGoal_r;
    curStep_nxt = curStep_r;
    {durW_nxt, jumpW_nxt, brW_nxt} = {durW_r, jumpW_r, brW_r};
    {voltW_nxt, freqW_nxt, phW_nxt} = {voltW_r, freqW_r, phW_r};
    tick_nxt = tick_r;
    rem_nxt = rem_r;
    loopStep_nxt = loopStep_r;
    loopCnt_nxt = loopCnt_r;
    inBranch_nxt = inBranch_r;
    retHold_nxt = retHold_r;
    retStep_nxt = retStep_r;
    retRem_nxt = retRem_r;
    outLatch = 1'b0;
    case (state_r)
      TSS_IDLE:
      begin
        // start needs an internal mode and steps 0 and 1 at least
        if (cmd_r[CTRL_START] && modeOk && (lastStep_r >= STEPW'(1)))
        begin
          {loadStep_nxt, loadWord_nxt, loadGoal_nxt} = {STEPW'(0), W_DUR, GOAL_START};
          // a chain that ran off the last step must not leak into the next run
          inBranch_nxt = 1'b0;
          state_nxt = TSS_LOAD;
        end
      end
      TSS_LOAD:
      begin
        // store answers one cycle after the word index
        case (loadWord_r)
          3'h1: durW_nxt = memRdData;
          3'h2: jumpW_nxt = memRdData;
          3'h3: brW_nxt = memRdData;
          3'h4: voltW_nxt = memRdData;
          3'h5: freqW_nxt = memRdData;
          3'h6: phW_nxt = memRdData;
          default: durW_nxt = durW_r;
        endcase
        loadWord_nxt = loadWord_r + 3'h1;
        if (loadWord_r == W_LAST)
        begin
          curStep_nxt = loadStep_r;
          loadWord_nxt = W_DUR;
          tick_nxt = 12'h0;
          outLatch = 1'b1;
          case (loadGoal_r)
            GOAL_RESUME:
            begin
              rem_nxt = retRem_r;
              state_nxt = retHold_r ? TSS_HOLD : TSS_RUN;
            end
            GOAL_STANDBY: state_nxt = TSS_IDLE;
            default:
            begin
              // a zero duration still lasts one time unit
              rem_nxt = (durW_nxt == 32'h0) ? 32'h1 : durW_nxt;
              state_nxt = TSS_ONWAIT;
            end
          endcase
        end
      end
      TSS_ONWAIT:
      begin
        // timer stays frozen until the start phase is met
        // dc mode has no phase fields, so it never waits on a phase
        if (!phW_r[ON_FIX] || onPhaseReached || (modeSel_r == TSS_MODE_INTERNAL_DC))
        begin
          state_nxt = TSS_RUN;
        end
      end
      TSS_RUN:
      begin
        if (rem_r == 32'h0)
        begin
          state_nxt = TSS_OFFWAIT;
        end
        else if (int'(tick_r) == TICK_CYCLES - 1)
        begin
          tick_nxt = 12'h0;
          rem_nxt = rem_r - 32'h1;
        end
        else
        begin
          tick_nxt = tick_r + 12'h1;
        end
      end
      TSS_OFFWAIT:
      begin
        // stop phase alignment adds to the step, not to its time
        if (!phW_r[OFF_FIX] || offPhaseReached || (modeSel_r == TSS_MODE_INTERNAL_DC))
        begin
          state_nxt = TSS_DECIDE;
        end
      end
      TSS_DECIDE:
      begin
        loadWord_nxt = W_DUR;
        loadGoal_nxt = GOAL_START;
        state_nxt = TSS_LOAD;
        if (jumpW_r[J_EN] && (jumpW_r[J_CNT_LSB +: 14] == 14'h0))
        begin
          loadStep_nxt = jumpW_r[STEPW-1:0];
        end
        else if (jumpW_r[J_EN] && ((loopStep_r != curStep_r) ||
                 (loopCnt_r < jumpW_r[J_CNT_LSB +: 14])))
        begin
          // a new loop owner restarts the count of taken jumps
          loopCnt_nxt = (loopStep_r != curStep_r) ? 14'h1 : loopCnt_r + 14'h1;
          loopStep_nxt = curStep_r;
          loadStep_nxt = jumpW_r[STEPW-1:0];
        end
        else
        begin
          if (jumpW_r[J_EN])
          begin
            loopCnt_nxt = 14'h0;
          end
          case (jumpW_r[TERM_LSB +: 2])
            TSS_TERM_CONTINUE_TO_NEXT:
            begin
              loadStep_nxt = atLast ? STEPW'(0) : nextStep;
              loadGoal_nxt = atLast ? GOAL_STANDBY : GOAL_START;
            end
            TSS_TERM_HOLD: state_nxt = TSS_HOLD;
            default:
            begin
              // end inside a branch returns to the interrupted step
              loadStep_nxt = inBranch_r ? retStep_r : STEPW'(0);
              loadGoal_nxt = inBranch_r ? GOAL_RESUME : GOAL_STANDBY;
              inBranch_nxt = 1'b0;
            end
          endcase
        end
      end
      TSS_HOLD:
      begin
        if (contGo)
        begin
          loadStep_nxt = atLast ? STEPW'(0) : nextStep;
          loadGoal_nxt = atLast ? GOAL_STANDBY : GOAL_START;
          loadWord_nxt = W_DUR;
          state_nxt = TSS_LOAD;
        end
      end
      default: state_nxt = TSS_IDLE;
    endcase
    // branch wins over step timing; one branch level only
    if ((state_r inside {TSS_ONWAIT, TSS_RUN, TSS_OFFWAIT, TSS_HOLD}) && !inBranch_r &&
        ((br1Go && brW_r[B1_EN]) || (br2Go && brW_r[B2_EN])))
    begin
      retStep_nxt = curStep_r;
      retRem_nxt = rem_r;
      retHold_nxt = (state_r == TSS_HOLD);
      inBranch_nxt = 1'b1;
      loadStep_nxt = (br1Go && brW_r[B1_EN]) ? brW_r[STEPW-1:0] : brW_r[B2_LSB +: STEPW];
      {loadWord_nxt, loadGoal_nxt} = {W_DUR, GOAL_START};
      state_nxt = TSS_LOAD;
    end
    // stop wins in every state but idle, back to standby
    if (cmd_r[CTRL_STOP] && (state_r != TSS_IDLE))
    begin
      {loadStep_nxt, loadWord_nxt, loadGoal_nxt} = {STEPW'(0), W_DUR, GOAL_STANDBY};
      inBranch_nxt = 1'b0;
      state_nxt = TSS_LOAD;
    end
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= TSS_IDLE;
      {loadStep_r, curStep_r, loopStep_r, retStep_r} <= '0;
      {loadWord_r, loadGoal_r, tick_r, loopCnt_r} <= '0;
      {durW_r, jumpW_r, brW_r, voltW_r, freqW_r, phW_r} <= '0;
      {rem_r, retRem_r, inBranch_r, retHold_r} <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      {loadStep_r, curStep_r, loopStep_r, retStep_r} <=
        {loadStep_nxt, curStep_nxt, loopStep_nxt, retStep_nxt};
      {loadWord_r, loadGoal_r, tick_r, loopCnt_r} <=
        {loadWord_nxt, loadGoal_nxt, tick_nxt, loopCnt_nxt};
      {durW_r, jumpW_r, brW_r} <= {durW_nxt, jumpW_nxt, brW_nxt};
      {voltW_r, freqW_r, phW_r} <= {voltW_nxt, freqW_nxt, phW_nxt};
      {rem_r, retRem_r, inBranch_r, retHold_r} <= {rem_nxt, retRem_nxt, inBranch_nxt, retHold_nxt};
    end
  end

  // generator outputs: step fields refreshed only when a step record is complete, hold and range flags every cycle
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {stepNumber, stepActive, holdActive, syncCode, rangeHigh} <= '0;
      {acVoltage, dcVoltage, frequency, waveSel} <= '0;
      {onPhase, onPhaseFixed, offPhase, offPhaseFixed} <= '0;
    end
    else
    begin
      holdActive <= (state_nxt == TSS_HOLD);
      rangeHigh <= rangeHi_r;
      if (outLatch)
      begin
        stepNumber <= loadStep_r;
        stepActive <= (loadGoal_r != GOAL_STANDBY);
        syncCode <= jumpW_r[SYNC_LSB +: 2];
        // fields a mode does not use are held at zero, except the phase values in dc mode, where only the fixed flags are cleared
        acVoltage <= (modeSel_r == TSS_MODE_INTERNAL_DC) ? 16'h0 :
                     clampAc(voltW_r[15:0], rangeHi_r);
        dcVoltage <= (modeSel_r == TSS_MODE_INTERNAL_AC) ? 16'sh0 :
                     clampDc(voltW_r[31:16], rangeHi_r);
        frequency <= (modeSel_r == TSS_MODE_INTERNAL_DC) ? 16'h0 : freqW_r[15:0];
        waveSel <= (modeSel_r == TSS_MODE_INTERNAL_DC) ? 8'h0 : freqW_r[WAVE_LSB +: 8];
        onPhase <= phW_nxt[11:0];
        onPhaseFixed <= phW_nxt[ON_FIX] && (modeSel_r != TSS_MODE_INTERNAL_DC);
        offPhase <= phW_nxt[OFF_LSB +: 12];
        offPhaseFixed <= phW_nxt[OFF_FIX] && (modeSel_r != TSS_MODE_INTERNAL_DC);
      end
    end
  end

  // checks beside the logic
  sequence loadToStandby;
    (state_r == TSS_LOAD) [*7] ##1 (state_r == TSS_IDLE);
  endsequence
  stepBound_a: assert property (@(posedge mclk) disable iff (!reset_n)
    int'(lastStep_r) <= STEPS - 1) else $error("program length beyond store");
  shortProgram_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_r == TSS_IDLE && lastStep_r == '0) |=> state_r == TSS_IDLE)
    else $error("one-step program started");
  endStandby_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_r == TSS_DECIDE && !jumpW_r[J_EN] && jumpW_r[TERM_LSB +: 2] == TSS_TERM_END &&
     !inBranch_r && !cmd_r[CTRL_STOP] && !br1Go && !br2Go) |=> loadToStandby ##1 stepNumber == '0)
    else $error("end did not reach standby");
  phaseFreeze_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_r == TSS_ONWAIT) |=> $stable(rem_r)) else $error("timer ran during phase wait");
  holdStays_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_r == TSS_HOLD && !contGo && !cmd_r[CTRL_STOP] && !br1Go && !br2Go) |=>
    (state_r == TSS_HOLD && holdActive)) else $error("hold left without continue");
  syncStart_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_r == TSS_ONWAIT) |-> syncCode == jumpW_r[SYNC_LSB +: 2])
    else $error("sync code not that of the started step");
  modeGate_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_r == TSS_IDLE && !modeOk) |=> state_r == TSS_IDLE)
    else $error("started outside internal modes");
  infiniteLoop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_r == TSS_DECIDE && jumpW_r[J_EN] && jumpW_r[J_CNT_LSB +: 14] == 14'h0 &&
     !cmd_r[CTRL_STOP] && !br1Go && !br2Go) |=> loadStep_r == $past(jumpW_r[STEPW-1:0]))
    else $error("endless jump not taken");
  dcMask_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (modeSel_r == TSS_MODE_INTERNAL_DC && $past(outLatch)) |-> acVoltage == 16'h0)
    else $error("ac level driven in dc mode");
  busAck_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low twice");
endmodule

// ===== tss_test_step_sequencer_tb_top.sv
// self-checking bench of the step sequencer with a stepped program
`timescale 1ns/10ps
module tss_test_step_sequencer_tb_top
  import tss_pkg::*;
;
  logic mclk, reset_n, avs_read, avs_write, avs_waitrequest, stepActive, holdActive;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0] keyCmd, syncCode;
  logic cK, b1K, b2K, onP, offP, rangeHigh;
  logic [STEPW-1:0] stepNumber, prevStep;
  logic prevAct;
  logic [15:0] acV; // ac level, masked in dc mode
  logic signed [15:0] dcV; // dc level of the running step
  int dv[3]; // dc level written into each step
  int num_errors = 0, n_checks = 0, t;
  int expQ[$]; // expected step order from the model
  int tg[3] = '{0, 0, 0}, en[3] = '{0, 1, 0}, cn[3] = '{0, 2, 0}, tm[3] = '{0, 2, 1}, sy[3];
  tss_test_step_sequencer u_tss_test_step_sequencer (.mclk(mclk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .branchOneKey(b1K), .branchTwoKey(b2K),
    .continueKey(cK), .onPhaseReached(onP), .offPhaseReached(offP), .stepNumber(stepNumber),
    .stepActive(stepActive), .holdActive(holdActive), .acVoltage(acV), .dcVoltage(dcV),
    .frequency(), .waveSel(), .onPhase(), .onPhaseFixed(), .offPhase(), .offPhaseFixed(),
    .syncCode(syncCode), .rangeHigh(rangeHigh));
  tss_operator_model u_tss_operator_model (.mclk(mclk), .keyCmd(keyCmd), .continueKey(cK),
    .branchOneKey(b1K), .branchTwoKey(b2K), .onPhaseReached(onP), .offPhaseReached(offP));
  always #20 mclk = ~mclk;
  task automatic final_report();
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) chk(0, 1);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // each new step start checked against the model order and its sync code
  always @(posedge mclk)
  begin
    if (stepActive === 1'b1 && (prevAct !== 1'b1 || stepNumber !== prevStep))
    begin
      if (expQ.size() == 0)
        chk(0, 1);
      else
      begin
        chk(32'(stepNumber), expQ[0]);
        chk(32'(acV), 32'h0);
        chk(32'(dcV), (dv[expQ[0]] > int'(DCV_MAX_HI)) ? int'(DCV_MAX_HI) : dv[expQ[0]]);
        chk(32'(syncCode), sy[expQ.pop_front()]);
      end
    end
    prevStep <= stepNumber;
    prevAct <= stepActive;
  end
  // watchdog well beyond the longest program run
  initial
  begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    final_report();
  end
  initial
  begin
    {mclk, reset_n, avs_read, avs_write, avs_address, avs_writedata, keyCmd} = '0;
    void'($urandom(74));
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    rchk(OFF_CONFIG, 32'h0);
    rchk(OFF_LAST, 32'h1);
    rchk(16'h0020, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h1);
    repeat (20) @(posedge mclk);
    chk(32'(stepActive), 32'h0);
    // program: step 1 jumps back to 0 twice, then holds; step 2 ends
    for (int s = 0; s < 3; s++)
    begin
      sy[s] = $urandom_range(0, 3);
      dv[s] = $urandom_range(0, 6000);
      bus(1'b1, OFF_MEMBASE + 16'(s * 32), $urandom_range(1, 2));
      bus(1'b1, OFF_MEMBASE + 16'(s * 32 + 4), 32'(tg[s] | en[s] << J_EN
        | cn[s] << J_CNT_LSB | tm[s] << TERM_LSB | sy[s] << SYNC_LSB));
      for (int k = 2; k < 6; k++) bus(1'b1, OFF_MEMBASE + 16'(s * 32 + k * 4),
        (k == 3) ? {16'(dv[s]), 16'hFFFF} : 32'h0);
    end
    bus(1'b1, OFF_LAST, 32'h2);
    bus(1'b1, OFF_CONFIG, 32'h5);
    // config lands at the acknowledge edge, the output flop one edge later
    repeat (2) @(posedge mclk);
    chk(32'(rangeHigh), 32'h1);
    t = 0;
    for (int k = 0, c = 0, u = 0; k < 20; k++)
    begin
      expQ.push_back(c);
      if (en[c] != 0 && (cn[c] == 0 || u < cn[c]))
      begin
        u++;
        c = tg[c];
      end
      else
      begin
        // only an exhausted jumping step clears the taken count
        if (en[c] != 0) u = 0;
        if (tm[c] == 1) break;
        c++;
      end
    end
    keyCmd <= 2'h2;
    @(posedge mclk);
    keyCmd <= 2'h0;
    repeat (12) @(posedge mclk);
    chk(32'(stepActive), 32'h0);
    bus(1'b1, OFF_CTRL, 32'h1);
    while (holdActive !== 1'b1 && t < 40000) begin @(posedge mclk); t++; end
    chk(32'(t < 40000), 32'h1);
    chk(32'(stepNumber), 32'h1);
    rchk(OFF_LOOP, 32'h0);
    repeat (100) @(posedge mclk);
    chk(32'(holdActive), 32'h1);
    keyCmd <= 2'h1;
    @(posedge mclk);
    keyCmd <= 2'h0;
    while (stepActive !== 1'b0 && t < 60000) begin @(posedge mclk); t++; end
    chk(32'(t < 60000), 32'h1);
    repeat (2) @(posedge mclk);
    chk(32'(stepNumber), 32'h0);
    chk(expQ.size(), 0);
    rchk(OFF_STATUS, 32'h0);
    final_report();
  end
endmodule
